// ---- src/hw_bp_defs.vh ----
/*
  Register offsets, field positions, reset values and cause codes of the
  breakpoint and watchpoint unit.
  Assumes it is included by its bare name in each design file that needs it.
*/
`ifndef HW_BP_DEFS_VH
`define HW_BP_DEFS_VH

// ----------------------------------------------------------------
// Register offsets (word addresses on the plain register port)
// ----------------------------------------------------------------
`define OFS_DEBUG_TYPE 8'h15
`define OFS_DEBUG_DATA 8'h16
`define OFS_IB_ADDR 8'h30
`define OFS_IB_CTRL 8'h40
`define OFS_DW_FIRST 8'h50
`define OFS_DW_SECOND 8'h60
`define OFS_DW_CTRL 8'h70
`define OFS_RW_MASK 8'h80
`define OFS_RW_VALUE 8'h90
`define OFS_RW_CTRL 8'h9c
`define OFS_IRQ_STATUS 8'ha0
`define OFS_IRQ_MASK 8'ha1

// ----------------------------------------------------------------
// Control word fields
// ----------------------------------------------------------------
`define BP_ENABLE_BIT 0
`define BP_COND_BIT 1
`define BP_LOAD_BIT 2
`define BP_THREAD_MSB 23
`define BP_THREAD_LSB 16

// Writable bits of each control word; the rest read as zero.
`define IB_CTRL_WMASK 32'h00ff0003
`define DW_CTRL_WMASK 32'h00ff0007
`define RW_CTRL_WMASK 32'h00ff0003

// ----------------------------------------------------------------
// Debug interrupt type fields and cause codes
// ----------------------------------------------------------------
`define TYPE_INDEX_MSB 17
`define TYPE_INDEX_LSB 16
`define TYPE_THREAD_MSB 15
`define TYPE_THREAD_LSB 8
`define TYPE_CAUSE_MSB 2
`define TYPE_CAUSE_LSB 0
`define TYPE_WMASK 32'h0003ff07
`define CAUSE_IBREAK 3'h3
`define CAUSE_DWATCH 3'h4
`define CAUSE_RWATCH 3'h5

// ----------------------------------------------------------------
// Interrupt status bits and reset values
// ----------------------------------------------------------------
`define IRQ_IB_BIT 0
`define IRQ_DW_BIT 1
`define IRQ_RW_BIT 2
`define IRQ_WIDTH 3
`define RESET_WORD 32'h00000000

`endif

// ---- src/bp_match_slot.v ----
/*
  One comparator slot: one instruction breakpoint, one data watchpoint and
  one resource watchpoint, all purely combinational.
  Assumes the core presents one qualified event of each kind per cycle,
  on the same clock as the unit, with the issuing thread number beside it.
*/
`timescale 1ns/1ns
`include "hw_bp_defs.vh"

module bp_match_slot #(
  parameter THREAD_BITS = 3
) (
  // Instruction breakpoint settings and program counter.
  input wire [31:0] ib_ctrl,
  input wire [31:0] ib_addr,
  input wire pc_valid,
  input wire [31:0] pc,
  input wire [THREAD_BITS-1:0] pc_thread,
  // Data watchpoint settings and memory access.
  input wire [31:0] dw_ctrl,
  input wire [31:0] dw_first,
  input wire [31:0] dw_second,
  input wire mem_valid,
  input wire [31:0] mem_addr,
  input wire mem_load,
  input wire [THREAD_BITS-1:0] mem_thread,
  // Resource watchpoint settings and resource operation.
  input wire [31:0] rw_ctrl,
  input wire [31:0] rw_mask,
  input wire [31:0] rw_value,
  input wire res_valid,
  input wire [31:0] res_id,
  input wire [THREAD_BITS-1:0] res_thread,
  // Match results.
  output wire ib_hit,
  output wire dw_hit,
  output wire rw_hit
);

  wire [7:0] ib_thr;
  wire [7:0] dw_thr;
  wire [7:0] rw_thr;
  wire dw_cond_a;
  wire dw_cond_b;
  wire dw_eligible;
  wire [31:0] res_masked;
  wire rw_cond_a;

  assign ib_thr = ib_ctrl[`BP_THREAD_MSB:`BP_THREAD_LSB];
  assign dw_thr = dw_ctrl[`BP_THREAD_MSB:`BP_THREAD_LSB];
  assign rw_thr = rw_ctrl[`BP_THREAD_MSB:`BP_THREAD_LSB];

  // Program counter compare, equal or unequal by the sense bit.
  assign ib_hit = pc_valid & ib_ctrl[`BP_ENABLE_BIT] & ib_thr[pc_thread]
    & (ib_ctrl[`BP_COND_BIT] ? (pc != ib_addr) : (pc == ib_addr));

  // Loads only count when the load bit allows them; stores always count.
  assign dw_eligible = mem_valid & dw_ctrl[`BP_ENABLE_BIT] & dw_thr[mem_thread]
    & (~mem_load | dw_ctrl[`BP_LOAD_BIT]);
  assign dw_cond_a = (mem_addr == dw_first);
  assign dw_cond_b = (mem_addr == dw_second);
  assign dw_hit = dw_eligible
    & (dw_ctrl[`BP_COND_BIT] ? (dw_cond_a | dw_cond_b) : (dw_cond_a & dw_cond_b));

  // Masked identifier compare; condition B is the inverse of A.
  assign res_masked = res_id & rw_mask;
  assign rw_cond_a = (res_masked == rw_value);
  assign rw_hit = res_valid & rw_ctrl[`BP_ENABLE_BIT] & rw_thr[res_thread]
    & (rw_ctrl[`BP_COND_BIT] ? ~rw_cond_a : rw_cond_a);

endmodule // bp_match_slot

// ---- src/hw_breakpoint_watchpoint_unit.v ----
/*
  Hardware breakpoint and watchpoint unit: four instruction breakpoints,
  four data watchpoints and four resource watchpoints, their registers on a
  plain register port, hit capture and the debug interrupt.
  Assumes the core drives its event buses on core_clk and that the register
  master keeps strobes one cycle long and never both at once.
*/
`timescale 1ns/1ns
`include "hw_bp_defs.vh"

module hw_breakpoint_watchpoint_unit #(
  parameter NUM_SLOTS = 4,
  parameter THREAD_BITS = 3
) (
  // Clock, reset and clock enable.
  input wire core_clk,
  input wire reset_n,
  input wire clk_en,
  // Register port.
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  // Instruction issue from the core.
  input wire pc_valid,
  input wire [31:0] pc,
  input wire [THREAD_BITS-1:0] pc_thread,
  // Load and store effective addresses from the core.
  input wire mem_valid,
  input wire [31:0] mem_addr,
  input wire mem_load,
  input wire [THREAD_BITS-1:0] mem_thread,
  // Resource operations from the core.
  input wire res_valid,
  input wire [31:0] res_id,
  input wire [THREAD_BITS-1:0] res_thread,
  // Debug request to the core and interrupt to the debug handler.
  output reg debug_req,
  output wire debug_irq
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  reg [31:0] ib_addr_r [0:NUM_SLOTS-1];
  reg [31:0] ib_ctrl_r [0:NUM_SLOTS-1];
  reg [31:0] dw_first_r [0:NUM_SLOTS-1];
  reg [31:0] dw_second_r [0:NUM_SLOTS-1];
  reg [31:0] dw_ctrl_r [0:NUM_SLOTS-1];
  reg [31:0] rw_mask_r [0:NUM_SLOTS-1];
  reg [31:0] rw_value_r [0:NUM_SLOTS-1];
  reg [31:0] rw_ctrl_r [0:NUM_SLOTS-1];
  reg [31:0] debug_type_r;
  reg [31:0] debug_data_r;
  reg [`IRQ_WIDTH-1:0] irq_status_r;
  reg [`IRQ_WIDTH-1:0] irq_mask_r;
  reg [31:0] type_nxt;
  reg [31:0] data_nxt;
  reg [31:0] rdata_nxt;
  wire [NUM_SLOTS-1:0] ib_hit;
  wire [NUM_SLOTS-1:0] dw_hit;
  wire [NUM_SLOTS-1:0] rw_hit;
  wire any_hit;
  wire [`IRQ_WIDTH-1:0] irq_events;
  wire [`IRQ_WIDTH-1:0] irq_clear;
  wire [`IRQ_WIDTH-1:0] irq_status_nxt;
  integer i;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Index of the lowest set bit of a four-wide hit vector.
  function [1:0] lowest_index;
    input [3:0] hits;
    begin
      if (hits[0])
        lowest_index = 2'h0;
      else if (hits[1])
        lowest_index = 2'h1;
      else if (hits[2])
        lowest_index = 2'h2;
      else
        lowest_index = 2'h3;
    end
  endfunction

  // True when the address falls in the four-word group at base.
  function in_group;
    input [7:0] addr;
    input [7:0] base;
    begin
      in_group = (addr[7:2] == base[7:2]);
    end
  endfunction

  // ----------------------------------------------------------------
  // Comparator slots
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_SLOTS; g = g + 1)
    begin : slot
      bp_match_slot #(
        .THREAD_BITS(THREAD_BITS)
      ) u_slot (
        .ib_ctrl(ib_ctrl_r[g]),
        .ib_addr(ib_addr_r[g]),
        .pc_valid(pc_valid),
        .pc(pc),
        .pc_thread(pc_thread),
        .dw_ctrl(dw_ctrl_r[g]),
        .dw_first(dw_first_r[g]),
        .dw_second(dw_second_r[g]),
        .mem_valid(mem_valid),
        .mem_addr(mem_addr),
        .mem_load(mem_load),
        .mem_thread(mem_thread),
        .rw_ctrl(rw_ctrl_r[g]),
        .rw_mask(rw_mask_r[g]),
        .rw_value(rw_value_r[g]),
        .res_valid(res_valid),
        .res_id(res_id),
        .res_thread(res_thread),
        .ib_hit(ib_hit[g]),
        .dw_hit(dw_hit[g]),
        .rw_hit(rw_hit[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Hit capture
  // ----------------------------------------------------------------
  assign any_hit = (|ib_hit) | (|dw_hit) | (|rw_hit);

  // Instruction breakpoints take precedence over data, data over resource.
  always @*
  begin
    type_nxt = debug_type_r;
    data_nxt = debug_data_r;
    if (reg_wr && reg_addr == `OFS_DEBUG_TYPE)
      type_nxt = reg_wdata & `TYPE_WMASK;
    if (reg_wr && reg_addr == `OFS_DEBUG_DATA)
      data_nxt = reg_wdata;
    // A hit in the same cycle as a software write wins, except that an instruction hit leaves a write to the debug data word in place.
    if (|ib_hit)
    begin
      type_nxt = `RESET_WORD;
      type_nxt[`TYPE_CAUSE_MSB:`TYPE_CAUSE_LSB] = `CAUSE_IBREAK;
      type_nxt[`TYPE_INDEX_MSB:`TYPE_INDEX_LSB] = lowest_index(ib_hit);
      type_nxt[`TYPE_THREAD_LSB+THREAD_BITS-1:`TYPE_THREAD_LSB] = pc_thread;
    end
    else if (|dw_hit)
    begin
      type_nxt = `RESET_WORD;
      type_nxt[`TYPE_CAUSE_MSB:`TYPE_CAUSE_LSB] = `CAUSE_DWATCH;
      type_nxt[`TYPE_INDEX_MSB:`TYPE_INDEX_LSB] = lowest_index(dw_hit);
      type_nxt[`TYPE_THREAD_LSB+THREAD_BITS-1:`TYPE_THREAD_LSB] = mem_thread;
      data_nxt = mem_addr;
    end
    else if (|rw_hit)
    begin
      type_nxt = `RESET_WORD;
      type_nxt[`TYPE_CAUSE_MSB:`TYPE_CAUSE_LSB] = `CAUSE_RWATCH;
      type_nxt[`TYPE_INDEX_MSB:`TYPE_INDEX_LSB] = lowest_index(rw_hit);
      type_nxt[`TYPE_THREAD_LSB+THREAD_BITS-1:`TYPE_THREAD_LSB] = res_thread;
      data_nxt = res_id;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status
  // ----------------------------------------------------------------
  assign irq_events = {|rw_hit, |dw_hit, |ib_hit};
  assign irq_clear = (reg_wr && reg_addr == `OFS_IRQ_STATUS) ? reg_wdata[`IRQ_WIDTH-1:0] : {`IRQ_WIDTH{1'b0}};
  // Write one to clear, but a new event in the same cycle keeps its bit.
  assign irq_status_nxt = (irq_status_r & ~irq_clear) | irq_events;
  assign debug_irq = |(irq_status_r & irq_mask_r);

  // ----------------------------------------------------------------
  // Read multiplexer
  // ----------------------------------------------------------------
  // Unmapped addresses read as zero.
  always @*
  begin
    rdata_nxt = `RESET_WORD;
    if (in_group(reg_addr, `OFS_IB_ADDR))
      rdata_nxt = ib_addr_r[reg_addr[1:0]];
    else if (in_group(reg_addr, `OFS_IB_CTRL))
      rdata_nxt = ib_ctrl_r[reg_addr[1:0]];
    else if (in_group(reg_addr, `OFS_DW_FIRST))
      rdata_nxt = dw_first_r[reg_addr[1:0]];
    else if (in_group(reg_addr, `OFS_DW_SECOND))
      rdata_nxt = dw_second_r[reg_addr[1:0]];
    else if (in_group(reg_addr, `OFS_DW_CTRL))
      rdata_nxt = dw_ctrl_r[reg_addr[1:0]];
    else if (in_group(reg_addr, `OFS_RW_MASK))
      rdata_nxt = rw_mask_r[reg_addr[1:0]];
    else if (in_group(reg_addr, `OFS_RW_VALUE))
      rdata_nxt = rw_value_r[reg_addr[1:0]];
    else if (in_group(reg_addr, `OFS_RW_CTRL))
      rdata_nxt = rw_ctrl_r[reg_addr[1:0]];
    else if (reg_addr == `OFS_DEBUG_TYPE)
      rdata_nxt = debug_type_r;
    else if (reg_addr == `OFS_DEBUG_DATA)
      rdata_nxt = debug_data_r;
    else if (reg_addr == `OFS_IRQ_STATUS)
      rdata_nxt = {{(32-`IRQ_WIDTH){1'b0}}, irq_status_r};
    else if (reg_addr == `OFS_IRQ_MASK)
      rdata_nxt = {{(32-`IRQ_WIDTH){1'b0}}, irq_mask_r};
  end

  // ----------------------------------------------------------------
  // Register writes and state
  // ----------------------------------------------------------------
  // Every control word, the capture registers and the interrupt state
  // clear at reset, even with clk_en low; otherwise clk_en low freezes everything.
  always @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      for (i = 0; i < NUM_SLOTS; i = i + 1)
      begin
        ib_addr_r[i] <= `RESET_WORD;
        ib_ctrl_r[i] <= `RESET_WORD;
        dw_first_r[i] <= `RESET_WORD;
        dw_second_r[i] <= `RESET_WORD;
        dw_ctrl_r[i] <= `RESET_WORD;
        rw_mask_r[i] <= `RESET_WORD;
        rw_value_r[i] <= `RESET_WORD;
        rw_ctrl_r[i] <= `RESET_WORD;
      end
      debug_type_r <= `RESET_WORD;
      debug_data_r <= `RESET_WORD;
      irq_status_r <= {`IRQ_WIDTH{1'b0}};
      irq_mask_r <= {`IRQ_WIDTH{1'b0}};
      reg_rdata <= `RESET_WORD;
      debug_req <= 1'b0;
    end
    else if (clk_en)
    begin
      if (reg_wr)
      begin
        if (in_group(reg_addr, `OFS_IB_ADDR))
          ib_addr_r[reg_addr[1:0]] <= reg_wdata;
        if (in_group(reg_addr, `OFS_IB_CTRL))
          ib_ctrl_r[reg_addr[1:0]] <= reg_wdata & `IB_CTRL_WMASK;
        if (in_group(reg_addr, `OFS_DW_FIRST))
          dw_first_r[reg_addr[1:0]] <= reg_wdata;
        if (in_group(reg_addr, `OFS_DW_SECOND))
          dw_second_r[reg_addr[1:0]] <= reg_wdata;
        if (in_group(reg_addr, `OFS_DW_CTRL))
          dw_ctrl_r[reg_addr[1:0]] <= reg_wdata & `DW_CTRL_WMASK;
        if (in_group(reg_addr, `OFS_RW_MASK))
          rw_mask_r[reg_addr[1:0]] <= reg_wdata;
        if (in_group(reg_addr, `OFS_RW_VALUE))
          rw_value_r[reg_addr[1:0]] <= reg_wdata;
        if (in_group(reg_addr, `OFS_RW_CTRL))
          rw_ctrl_r[reg_addr[1:0]] <= reg_wdata & `RW_CTRL_WMASK;
        if (reg_addr == `OFS_IRQ_MASK)
          irq_mask_r <= reg_wdata[`IRQ_WIDTH-1:0];
      end
      debug_type_r <= type_nxt;
      debug_data_r <= data_nxt;
      irq_status_r <= irq_status_nxt;
      // Read data stands only in the cycle after the read strobe.
      reg_rdata <= reg_rd ? rdata_nxt : `RESET_WORD;
      // One-cycle request to the core for each cycle with a hit.
      debug_req <= any_hit;
    end
  end

endmodule // hw_breakpoint_watchpoint_unit

// ---- testbench/hw_bp_checker_properties.sv ----
/*
  Checker for the breakpoint and watchpoint unit, bound to its top module.
  Assumes one clock, a synchronous active-low reset and clk_en low only while no read or hit is pending.
*/
`timescale 1ns/1ns
module hw_bp_checker (
  // Clock and reset.
  input wire core_clk,
  input wire reset_n,
  // Register port and event valids.
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_rdata,
  input wire pc_valid,
  input wire mem_valid,
  input wire res_valid,
  // Debug outputs.
  input wire debug_req,
  input wire debug_irq
);
  reg [11:0] enables_r;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);
  // Shadow of each control word's enable bit, so a unit with all comparators off can be held silent.
  always @(posedge core_clk)
  begin
    if (!reset_n)
      enables_r <= 12'h000;
    else if (reg_wr && reg_addr[7:2] == 6'h10)
      enables_r[reg_addr[1:0]] <= reg_wdata[0];
    else if (reg_wr && reg_addr[7:2] == 6'h1c)
      enables_r[4 + reg_addr[1:0]] <= reg_wdata[0];
    else if (reg_wr && reg_addr[7:2] == 6'h27)
      enables_r[8 + reg_addr[1:0]] <= reg_wdata[0];
  end
  a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data not zero outside a read");
  a_req_has_cause: assert property (debug_req |-> $past(pc_valid || mem_valid || res_valid))
    else $error("debug request without an event");
  a_quiet_when_off: assert property (enables_r == 12'h000 |=> !debug_req)
    else $error("debug request while every comparator is off");
  a_irq_rise_cause: assert property ($rose(debug_irq) |-> debug_req || $past(reg_wr && reg_addr == 8'ha1))
    else $error("interrupt rose without a hit or mask write");
  a_ib_ctrl_reserved: assert property ($past(reg_rd && reg_addr[7:2] == 6'h10) |-> (reg_rdata & 32'hff00fffc) == 32'h0)
    else $error("instruction control reserved bits set");
  a_dw_ctrl_reserved: assert property ($past(reg_rd && reg_addr[7:2] == 6'h1c) |-> (reg_rdata & 32'hff00fff8) == 32'h0)
    else $error("data control reserved bits set");
  a_rw_ctrl_reserved: assert property ($past(reg_rd && reg_addr[7:2] == 6'h27) |-> (reg_rdata & 32'hff00fffc) == 32'h0)
    else $error("resource control reserved bits set");
  a_type_reserved: assert property ($past(reg_rd && reg_addr == 8'h15) |-> (reg_rdata & 32'hfffc00f8) == 32'h0)
    else $error("debug type reserved bits set");
endmodule // hw_bp_checker

bind hw_breakpoint_watchpoint_unit hw_bp_checker u_hw_bp_checker (
  .core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pc_valid(pc_valid), .mem_valid(mem_valid), .res_valid(res_valid),
  .debug_req(debug_req), .debug_irq(debug_irq)
);

// ---- testbench/core_event_model.sv ----
/*
  Model of the core issuing instructions, memory accesses and resource operations.
  Assumes the bench calls issue from one process, one event cycle per call.
*/
`timescale 1ns/1ns
module core_event_model (
  // Clock.
  input wire core_clk,
  // Event buses.
  output reg pc_valid,
  output reg [31:0] pc,
  output reg [2:0] pc_thread,
  output reg mem_valid,
  output reg [31:0] mem_addr,
  output reg mem_load,
  output reg [2:0] mem_thread,
  output reg res_valid,
  output reg [31:0] res_id,
  output reg [2:0] res_thread
);
  // Quiet buses at time zero.
  initial
  begin
    {pc_valid, mem_valid, res_valid, mem_load} = 4'h0;
    {pc, mem_addr, res_id} = 96'h0;
    {pc_thread, mem_thread, res_thread} = 9'h0;
  end
  // One event cycle; afterwards the buses show the inverse so stale values never look valid.
  task issue(input [2:0] kinds, input [31:0] p, input [31:0] a, input ld, input [31:0] r, input [2:0] thr);
  begin
    @(posedge core_clk);
    {res_valid, mem_valid, pc_valid} <= kinds;
    {pc, mem_addr, res_id, mem_load} <= {p, a, r, ld};
    {pc_thread, mem_thread, res_thread} <= {thr, thr, thr};
    @(posedge core_clk);
    {res_valid, mem_valid, pc_valid} <= 3'h0;
    {pc, mem_addr, res_id, mem_load} <= ~{p, a, r, ld};
    {pc_thread, mem_thread, res_thread} <= ~{thr, thr, thr};
  end
  endtask
endmodule // core_event_model

// ---- testbench/test_hw_breakpoint_watchpoint_unit.sv ----
/*
  Bench for the breakpoint and watchpoint unit: register tasks, event model and checks.
  Assumes clk_en drops only in the freeze test and the event model owns the event buses.
*/
`timescale 1ns/1ns
module test_hw_breakpoint_watchpoint_unit;
  reg core_clk, reset_n, reg_wr, reg_rd, clk_en;
  reg [7:0] reg_addr;
  reg [31:0] reg_wdata;
  wire [31:0] reg_rdata, pc, mem_addr, res_id;
  wire [2:0] pc_thread, mem_thread, res_thread;
  wire pc_valid, mem_valid, mem_load, res_valid, debug_req, debug_irq;
  integer fails, checked, cycles;
  hw_breakpoint_watchpoint_unit u_hw_breakpoint_watchpoint_unit (.core_clk(core_clk), .reset_n(reset_n),
    .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pc_valid(pc_valid), .pc(pc), .pc_thread(pc_thread), .mem_valid(mem_valid),
    .mem_addr(mem_addr), .mem_load(mem_load), .mem_thread(mem_thread), .res_valid(res_valid), .res_id(res_id),
    .res_thread(res_thread), .debug_req(debug_req), .debug_irq(debug_irq));
  core_event_model u_core_event_model (.core_clk(core_clk), .pc_valid(pc_valid), .pc(pc),
    .pc_thread(pc_thread), .mem_valid(mem_valid), .mem_addr(mem_addr), .mem_load(mem_load),
    .mem_thread(mem_thread), .res_valid(res_valid), .res_id(res_id), .res_thread(res_thread));
  // ----------------------------------------------------------------
  // Clock, timeout and shared tasks
  // ----------------------------------------------------------------
  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  task test_done;
  begin
    if (fails == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  end
  endtask
  // Cuts a hung run short.
  always @(posedge core_clk)
  begin
    cycles = cycles + 1;
    if (cycles == 5000)
    begin
      fails = fails + 1;
      test_done;
    end
  end
  task chk(input [31:0] got, input [31:0] exp);
  begin
    checked = checked + 1;
    if (got !== exp)
    begin
      fails = fails + 1;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask
  task wr(input [7:0] a, input [31:0] d);
  begin
    @(posedge core_clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge core_clk);
    reg_wr <= 1'b0;
  end
  endtask
  task rd(input [7:0] a, input [31:0] exp);
  begin
    @(posedge core_clk);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  end
  endtask
  task wrd(input [7:0] a, input [31:0] d, input [31:0] exp);
  begin
    wr(a, d);
    rd(a, exp);
  end
  endtask
  // One event cycle, the debug request one cycle later, and the recorded type on a hit.
  task ev(input [2:0] k, input [31:0] p, input [31:0] a, input ld, input [31:0] r, input [2:0] thr,
    input exp_req, input [31:0] exp_type);
  begin
    u_core_event_model.issue(k, p, a, ld, r, thr);
    #1 chk({31'h0, debug_req}, {31'h0, exp_req});
    if (exp_req)
      rd(8'h15, exp_type);
  end
  endtask
  // Main sequence.
  initial
  begin
    {reset_n, reg_wr, reg_rd, reg_addr, reg_wdata} = 43'h0;
    {fails, checked, cycles} = 96'h0;
    clk_en = 1'b1;
    repeat (12) @(posedge core_clk);
    reset_n <= 1'b1;
    rd(8'h40, 32'h0);
    rd(8'h73, 32'h0);
    rd(8'h9e, 32'h0);
    rd(8'ha0, 32'h0);
    rd(8'h00, 32'h0);
    wrd(8'h41, 32'hffffffff, 32'h00ff0003);
    wrd(8'h72, 32'hffffffff, 32'h00ff0007);
    wrd(8'h9f, 32'hffffffff, 32'h00ff0003);
    wrd(8'h51, 32'ha5a5a5a5, 32'ha5a5a5a5);
    wrd(8'h62, 32'h5a5a5a5a, 32'h5a5a5a5a);
    wrd(8'h83, 32'hc3c3c3c3, 32'hc3c3c3c3);
    wrd(8'h93, 32'h3c3c3c3c, 32'h3c3c3c3c);
    wrd(8'h15, 32'hffffffff, 32'h0003ff07);
    wr(8'h41, 32'h0);
    wr(8'h72, 32'h0);
    wr(8'h9f, 32'h0);
    wr(8'h32, 32'h100);
    wr(8'h33, 32'h100);
    wr(8'h42, 32'h00020001);
    wr(8'h43, 32'h00020001);
    ev(3'h1, 32'h100, 32'h0, 1'b0, 32'h0, 3'h0, 1'b0, 32'h0);
    ev(3'h1, 32'h100, 32'h0, 1'b0, 32'h0, 3'h1, 1'b1, 32'h00020103);
    wr(8'h42, 32'h00020003);
    wr(8'h43, 32'h0);
    ev(3'h1, 32'h100, 32'h0, 1'b0, 32'h0, 3'h1, 1'b0, 32'h0);
    ev(3'h1, 32'h104, 32'h0, 1'b0, 32'h0, 3'h1, 1'b1, 32'h00020103);
    wr(8'h42, 32'h0);
    wr(8'h51, 32'h2000);
    wr(8'h61, 32'h3000);
    wr(8'h71, 32'h00040001);
    ev(3'h2, 32'h0, 32'h3000, 1'b0, 32'h0, 3'h2, 1'b0, 32'h0);
    wr(8'h61, 32'h2000);
    ev(3'h2, 32'h0, 32'h2000, 1'b0, 32'h0, 3'h2, 1'b1, 32'h00010204);
    rd(8'h16, 32'h2000);
    wr(8'h61, 32'h3000);
    wr(8'h71, 32'h00040003);
    ev(3'h2, 32'h0, 32'h3000, 1'b1, 32'h0, 3'h2, 1'b0, 32'h0);
    wr(8'h71, 32'h00040007);
    ev(3'h2, 32'h0, 32'h3000, 1'b1, 32'h0, 3'h2, 1'b1, 32'h00010204);
    rd(8'h16, 32'h3000);
    wr(8'h71, 32'h0);
    wr(8'h80, 32'h0000ff00);
    wr(8'h90, 32'h00001200);
    wr(8'h9c, 32'h00080001);
    ev(3'h4, 32'h0, 32'h0, 1'b0, 32'h00ab12cd, 3'h3, 1'b1, 32'h00000305);
    rd(8'h16, 32'h00ab12cd);
    wr(8'h9c, 32'h00080003);
    ev(3'h4, 32'h0, 32'h0, 1'b0, 32'h00ab12cd, 3'h3, 1'b0, 32'h0);
    ev(3'h4, 32'h0, 32'h0, 1'b0, 32'h00001300, 3'h3, 1'b1, 32'h00000305);
    rd(8'ha0, 32'h7);
    #1 chk({31'h0, debug_irq}, 32'h0);
    wr(8'ha1, 32'h1);
    #1 chk({31'h0, debug_irq}, 32'h1);
    wr(8'ha0, 32'h1);
    #1 chk({31'h0, debug_irq}, 32'h0);
    rd(8'ha0, 32'h6);
    wr(8'ha1, 32'h6);
    #1 chk({31'h0, debug_irq}, 32'h1);
    wr(8'ha0, 32'h6);
    rd(8'ha0, 32'h0);
    chk({31'h0, debug_irq}, 32'h0);
    // A write while the clock enable is low must leave the register untouched.
    @(posedge core_clk);
    clk_en <= 1'b0;
    wr(8'h90, 32'hffffffff);
    clk_en <= 1'b1;
    rd(8'h90, 32'h00001200);
    // A reset in mid-run clears the armed resource watchpoint, so a matching operation stays silent.
    @(posedge core_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    rd(8'h9c, 32'h0);
    ev(3'h4, 32'h0, 32'h0, 1'b0, 32'h00001300, 3'h3, 1'b0, 32'h0);
    chk({31'h0, debug_irq}, 32'h0);
    test_done;
  end
endmodule // test_hw_breakpoint_watchpoint_unit
